// [design/tof_host_control_registers.sv]
// Host control registers of a distance sensor, reached over I2C.
// Assumes firmware-side strobes are on i_clk; I2C pins are asynchronous.
// Function
// - Writing reset bit issues global processor reset.
// - Reset bit clears itself after triggering.
// - Not ready: only upper registers are served.
// - Ready bit set by firmware only.
// - Oscillator bit: one active, zero standby; resets one.
// - Zero-to-one write starts oscillator, power-on interrupt.
// - Firmware chooses reset or idle on power-on.
// - Writing zero raises power-down processor interrupt.
// - Firmware finishes power-down, then enters standby.
// - Histogram flag sets when histogram ready.
// - Object flag sets on detection result.
// - Every result sets flag, even no target.
// - Object flag and enable pull pin low.
// - Histogram flag and enable pull pin low.
// - Writing one clears object flag.
// - Running register reports measurement or bootloader code.
// - Enable bits gate flags onto the pin.
module tof_host_control_registers
    import tof_ctrl_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // I2C pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    // Firmware side
    input  wire logic       i_fw_cpu_ready_set,
    input  wire logic       i_fw_app_valid,
    input  wire logic [7:0] i_fw_app_code,
    input  wire logic       i_fw_standby,
    input  wire logic       i_object_result_evt,
    input  wire logic       i_histogram_ready_evt,
    input  wire logic       i_object_result_irq_enable,
    input  wire logic       i_histogram_irq_enable,
    output logic            o_cpu_global_rst,
    output logic            o_osc_run,
    output logic            o_power_on_cpu_irq,
    output logic            o_power_down_cpu_irq,
    output logic [7:0]      o_requested_app_code,
    // Interrupt pin, open drain
    output logic            o_int_out,
    output logic            o_int_oe
);
    typedef struct packed {
        i2c_state_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic       rnw;
        logic       nack;
        logic       sda_oe;
        logic [2:0] rst_cnt;
        logic       cpu_rst;
        logic       cpu_ready;
        logic       osc_power;
        logic       osc_run;
        logic       pon_irq;
        logic       pdn_irq;
        logic [7:0] app_running;
        logic [7:0] app_rev;
        logic [7:0] app_req;
        logic       obj_flag;
        logic       histo_flag;
        logic       int_oe;
        logic       zero;
    } state_s;

    state_s     s_q;
    state_s     s_d;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    i2c_line_if line ();

    i2c_pin_sync u_pin_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_scl (i_scl),
        .i_sda (i_sda),
        .line  (line.src)
    );

    // Host read view of one address
    function automatic logic [7:0] read_reg(input logic [7:0] a, input state_s s);
        logic [7:0] r;
        r = 8'h00;
        if (a == ADDR_ENABLE) begin
            r[BIT_CPU_RESET] = s.cpu_rst;
            r[BIT_CPU_READY] = s.cpu_ready;
            r[BIT_OSC_POWER] = s.osc_power;
        end else if (a == ADDR_INT_FLAGS) begin
            r[BIT_HISTO] = s.histo_flag;
            r[BIT_OBJ]   = s.obj_flag;
        end else if (!s.cpu_ready) begin
            r = 8'h00;
        end else if (a == ADDR_APP_RUNNING) begin
            r = s.app_running;
        end else if (a == ADDR_APP_REV) begin
            r = s.app_rev;
        end else if (a == ADDR_APP_REQ) begin
            r = s.app_req;
        end
        return r;
    endfunction

    always_comb begin
        s_d         = s_q;
        wr_en       = 1'b0;
        wr_addr     = s_q.ptr;
        wr_data     = s_q.sh;
        s_d.pon_irq = 1'b0;
        s_d.pdn_irq = 1'b0;
        s_d.zero    = 1'b0;

        // Serial engine; stop and start abort any transfer
        if (line.stop) begin
            s_d.st     = ST_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (line.start) begin
            s_d.st     = ST_ADDR;
            s_d.cnt    = 4'h0;
            s_d.sda_oe = 1'b0;
        end else if (line.scl_rise) begin
            if (s_q.st == ST_RDATA) begin
                s_d.cnt = s_q.cnt + 4'h1;
            end else if (s_q.st == ST_RDATA_ACK) begin
                s_d.nack = line.sda;
            end else if (s_q.st == ST_ADDR || s_q.st == ST_PTR || s_q.st == ST_WDATA) begin
                s_d.sh  = {s_q.sh[6:0], line.sda};
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end else if (line.scl_fall) begin
            // Data only changes while SCL is low
            case (s_q.st)
                ST_ADDR: begin
                    if (s_q.cnt == BITS_PER_BYTE) begin
                        if (s_q.sh[7:1] == SLAVE_ADDR) begin
                            s_d.st     = ST_ADDR_ACK;
                            s_d.sda_oe = 1'b1;
                            s_d.rnw    = s_q.sh[0];
                        end else begin
                            s_d.st = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RDATA_ACK: begin
                    if (s_q.st == ST_RDATA_ACK && s_q.nack) begin
                        s_d.st     = ST_IDLE;
                        s_d.sda_oe = 1'b0;
                    end else if (s_q.rnw) begin
                        s_d.sh     = read_reg(s_q.ptr, s_q);
                        s_d.sda_oe = ~s_d.sh[7];
                        s_d.ptr    = s_q.ptr + 8'h01;
                        s_d.cnt    = 4'h0;
                        s_d.st     = ST_RDATA;
                    end else begin
                        s_d.sda_oe = 1'b0;
                        s_d.cnt    = 4'h0;
                        s_d.st     = ST_PTR;
                    end
                end
                ST_PTR: begin
                    if (s_q.cnt == BITS_PER_BYTE) begin
                        s_d.ptr    = s_q.sh;
                        s_d.sda_oe = 1'b1;
                        s_d.st     = ST_PTR_ACK;
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    s_d.sda_oe = 1'b0;
                    s_d.cnt    = 4'h0;
                    s_d.st     = ST_WDATA;
                end
                ST_WDATA: begin
                    if (s_q.cnt == BITS_PER_BYTE) begin
                        wr_en      = 1'b1;
                        s_d.ptr    = s_q.ptr + 8'h01;
                        s_d.sda_oe = 1'b1;
                        s_d.st     = ST_WDATA_ACK;
                    end
                end
                ST_RDATA: begin
                    if (s_q.cnt == BITS_PER_BYTE) begin
                        s_d.sda_oe = 1'b0;
                        s_d.st     = ST_RDATA_ACK;
                    end else begin
                        s_d.sh     = {s_q.sh[6:0], 1'b0};
                        s_d.sda_oe = ~s_q.sh[6];
                    end
                end
                default: begin
                    s_d.st = ST_IDLE;
                end
            endcase
        end

        // Firmware side updates
        if (s_q.rst_cnt != 3'h0) begin
            s_d.rst_cnt = s_q.rst_cnt - 3'h1;
        end
        if (i_fw_cpu_ready_set) begin
            s_d.cpu_ready = 1'b1;
        end
        if (i_fw_app_valid) begin
            s_d.app_running = i_fw_app_code;
        end
        if (i_fw_standby && !s_q.osc_power) begin
            s_d.osc_run = 1'b0;
        end

        // Host writes; ADDR_APP_REV and ADDR_APP_REQ take the whole byte, ADDR_ENABLE and ADDR_INT_FLAGS act per bit
        if (wr_en) begin
            if (wr_addr == ADDR_ENABLE) begin
                if (wr_data[BIT_CPU_RESET]) begin
                    s_d.rst_cnt = CPU_RST_CYCLES;
                end
                s_d.osc_power = wr_data[BIT_OSC_POWER];
                if (wr_data[BIT_OSC_POWER] && !s_q.osc_power) begin
                    s_d.osc_run = 1'b1;
                    s_d.pon_irq = 1'b1;
                end else if (!wr_data[BIT_OSC_POWER]) begin
                    s_d.pdn_irq = 1'b1;
                end
            end else if (wr_addr == ADDR_INT_FLAGS) begin
                if (wr_data[BIT_OBJ]) begin
                    s_d.obj_flag = 1'b0;
                end
                if (wr_data[BIT_HISTO]) begin
                    s_d.histo_flag = 1'b0;
                end
            end else if (s_q.cpu_ready && wr_addr == ADDR_APP_REV) begin
                s_d.app_rev = wr_data;
            end else if (s_q.cpu_ready && wr_addr == ADDR_APP_REQ) begin
                s_d.app_req = wr_data;
            end
        end

        // Events after clears, so a same-cycle event is never lost
        if (i_object_result_evt) begin
            s_d.obj_flag = 1'b1;
        end
        if (i_histogram_ready_evt) begin
            s_d.histo_flag = 1'b1;
        end

        // Pin follows the registered flags one cycle later
        s_d.int_oe = (s_q.obj_flag && i_object_result_irq_enable)
                  || (s_q.histo_flag && i_histogram_irq_enable);

        // Global reset clears processor-side state while it lasts
        s_d.cpu_rst = (s_d.rst_cnt != 3'h0);
        if (s_d.cpu_rst) begin
            s_d.cpu_ready   = 1'b0;
            s_d.app_running = RST_APP_RUNNING;
            s_d.app_rev     = RST_APP_REV;
            s_d.app_req     = RST_APP_REQ;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q           <= '0;
            s_q.osc_power <= RST_OSC_POWER;
            s_q.osc_run   <= RST_OSC_POWER;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sda_out            = s_q.zero;
    assign o_sda_oe             = s_q.sda_oe;
    assign o_cpu_global_rst     = s_q.cpu_rst;
    assign o_osc_run            = s_q.osc_run;
    assign o_power_on_cpu_irq   = s_q.pon_irq;
    assign o_power_down_cpu_irq = s_q.pdn_irq;
    assign o_requested_app_code = s_q.app_req;
    assign o_int_out            = s_q.zero;
    assign o_int_oe             = s_q.int_oe;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    property p_rst_pulse;
        wr_en && wr_addr == ADDR_ENABLE && wr_data[BIT_CPU_RESET]
        |=> o_cpu_global_rst[*4] ##1 !o_cpu_global_rst;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("global reset pulse has wrong length");
    property p_rst_clears;
        o_cpu_global_rst |-> !s_q.cpu_ready && o_requested_app_code == RST_APP_REQ;
    endproperty
    a_rst_clears: assert property (p_rst_clears)
        else $error("processor state not cleared during global reset");
    property p_ready_source;
        $rose(s_q.cpu_ready) |-> $past(i_fw_cpu_ready_set);
    endproperty
    a_ready_source: assert property (p_ready_source)
        else $error("ready bit set without firmware");
    property p_locked_low;
        wr_en && wr_addr < ADDR_ENABLE && !s_q.cpu_ready |=> $stable(o_requested_app_code);
    endproperty
    a_locked_low: assert property (p_locked_low)
        else $error("low register written while not ready");

    property p_power_on;
        wr_en && wr_addr == ADDR_ENABLE && wr_data[BIT_OSC_POWER] && !s_q.osc_power
        |=> o_power_on_cpu_irq && o_osc_run ##1 !o_power_on_cpu_irq;
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("oscillator start or power-on interrupt missing");
    property p_power_down;
        wr_en && wr_addr == ADDR_ENABLE && !wr_data[BIT_OSC_POWER]
        |=> o_power_down_cpu_irq && !s_q.osc_power;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down interrupt missing");

    property p_standby;
        i_fw_standby && !s_q.osc_power && !wr_en |=> !o_osc_run;
    endproperty
    a_standby: assert property (p_standby)
        else $error("oscillator still running after standby");

    property p_obj_set;
        i_object_result_evt |=> s_q.obj_flag;
    endproperty
    a_obj_set: assert property (p_obj_set)
        else $error("object flag not set by result");
    property p_histo_set;
        i_histogram_ready_evt |=> s_q.histo_flag;
    endproperty
    a_histo_set: assert property (p_histo_set)
        else $error("histogram flag not set");

    property p_obj_clear;
        wr_en && wr_addr == ADDR_INT_FLAGS && wr_data[BIT_OBJ] && !i_object_result_evt
        |=> !s_q.obj_flag;
    endproperty
    a_obj_clear: assert property (p_obj_clear)
        else $error("object flag not cleared by write one");

    property p_pin_low;
        (s_q.obj_flag && i_object_result_irq_enable)
        || (s_q.histo_flag && i_histogram_irq_enable) |=> o_int_oe;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("interrupt pin not pulled low");
    property p_pin_released;
        !(s_q.obj_flag && i_object_result_irq_enable)
        && !(s_q.histo_flag && i_histogram_irq_enable) |=> !o_int_oe;
    endproperty
    a_pin_released: assert property (p_pin_released)
        else $error("interrupt pin not released");
endmodule // tof_host_control_registers

// [design/tof_ctrl_pkg.sv]
// Package: addresses, fields, reset values and I2C states.
// Assumes one 250 MHz clock and a synchronous active-high reset.
package tof_ctrl_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_APP_RUNNING = 8'h00;
    localparam logic [7:0] ADDR_APP_REV     = 8'h01;
    localparam logic [7:0] ADDR_APP_REQ     = 8'h02;
    localparam logic [7:0] ADDR_ENABLE      = 8'hE0;
    localparam logic [7:0] ADDR_INT_FLAGS   = 8'hE1;

    // Application codes
    localparam logic [7:0] APP_CODE_BOOT = 8'h80;
    localparam logic [7:0] APP_CODE_MEAS = 8'hC0;

    // Field positions
    localparam int BIT_CPU_RESET = 7;
    localparam int BIT_CPU_READY = 6;
    localparam int BIT_OSC_POWER = 0;
    localparam int BIT_HISTO     = 1;
    localparam int BIT_OBJ       = 0;

    // Reset values
    localparam logic [7:0] RST_APP_RUNNING = 8'h00;
    localparam logic [7:0] RST_APP_REV     = 8'h00;
    localparam logic [7:0] RST_APP_REQ     = 8'h00;
    localparam logic       RST_OSC_POWER   = 1'b1;

    // Timing and framing
    localparam logic [2:0] CPU_RST_CYCLES = 3'h4;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [6:0] DEF_SLAVE_ADDR = 7'h2A;

    // Serial engine states, Gray along the write path
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h3,
        ST_PTR       = 4'h2,
        ST_PTR_ACK   = 4'h6,
        ST_WDATA     = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA     = 4'h4,
        ST_RDATA_ACK = 4'hC
    } i2c_state_e;
endpackage

// [design/i2c_line_if.sv]
// Interface: synchronised I2C line events between pin stage and engine.
// Assumes all events are one-cycle pulses on the core clock.
interface i2c_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
    modport dst (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// [design/i2c_pin_sync.sv]
// Pin stage: two-flop synchronisers on SCL and SDA plus edge events.
// Assumes the pins are asynchronous; the bus idles high.
module i2c_pin_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_scl,
    input  wire logic i_sda,
    i2c_line_if.src   line
);
    typedef struct packed {
        logic scl_meta;
        logic scl_sync;
        logic scl_prev;
        logic sda_meta;
        logic sda_sync;
        logic sda_prev;
    } sync_s;

    sync_s s_q;
    sync_s s_d;

    always_comb begin
        s_d          = s_q;
        s_d.scl_meta = i_scl;
        s_d.scl_sync = s_q.scl_meta;
        s_d.scl_prev = s_q.scl_sync;
        s_d.sda_meta = i_sda;
        s_d.sda_sync = s_q.sda_meta;
        s_d.sda_prev = s_q.sda_sync;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // Only the second and third flops feed the edge logic
    assign line.scl_rise = s_q.scl_sync & ~s_q.scl_prev;
    assign line.scl_fall = ~s_q.scl_sync & s_q.scl_prev;
    assign line.start    = s_q.scl_sync & s_q.scl_prev & s_q.sda_prev & ~s_q.sda_sync;
    assign line.stop     = s_q.scl_sync & s_q.scl_prev & ~s_q.sda_prev & s_q.sda_sync;
    assign line.sda      = s_q.sda_sync;
endmodule // i2c_pin_sync

// [tb/i2c_host_model.sv]
// Host controller model: bit-level I2C master with open-drain data drive.
// Assumes a pull-up on SDA and a target that never stretches the clock.
module i2c_host_model
    import tof_ctrl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEF_SLAVE_ADDR
) (
    // Core clock paces the bus
    input  wire logic i_clk,
    // Resolved data line
    input  wire logic i_sda,
    // Bus drive
    output logic      o_scl,
    output logic      o_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quarter bit; the target answers 3-4 cycles after a fall
    localparam int QTR = 5;

    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    task automatic wait_q();
        repeat (QTR) @(posedge i_clk);
    endtask

    // Works from idle and as a repeated start
    task automatic send_start();
        o_sda_oe <= 1'b0;
        wait_q();
        o_scl <= 1'b1;
        wait_q();
        o_sda_oe <= 1'b1;
        wait_q();
        o_scl <= 1'b0;
        wait_q();
    endtask

    task automatic send_stop();
        o_sda_oe <= 1'b1;
        wait_q();
        o_scl <= 1'b1;
        wait_q();
        o_sda_oe <= 1'b0;
        wait_q();
    endtask

    // Data settles while SCL is low, sampled mid-high
    task automatic clk_bit(input logic b, output logic r);
        o_sda_oe <= ~b;
        wait_q();
        o_scl <= 1'b1;
        wait_q();
        r = i_sda;
        wait_q();
        o_scl <= 1'b0;
        wait_q();
    endtask

    task automatic put_byte(input logic [7:0] d, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ok = ok & ~r;
    endtask

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] dat, output logic ok);
        ok = 1'b1;
        send_start();
        put_byte({dev, 1'b0}, ok);
        put_byte(ptr, ok);
        put_byte(dat, ok);
        send_stop();
    endtask

    // Single-byte read, NACK ends it
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] dat, output logic ok);
        logic r;
        ok = 1'b1;
        send_start();
        put_byte({DEV_ADDR, 1'b0}, ok);
        put_byte(ptr, ok);
        send_start();
        put_byte({DEV_ADDR, 1'b1}, ok);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, dat[i]);
        end
        clk_bit(1'b1, r);
        send_stop();
    endtask
endmodule // i2c_host_model

// [tb/tof_host_control_registers_test.sv]
// Testbench: register block driven through the I2C host model.
// Assumes pull-ups on SDA and the interrupt pin, default slave address.
module tof_host_control_registers_test
    import tof_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TIMEOUT = 80000;

    logic       i_clk;
    logic       i_rst;
    logic [3:0] pulse_q;
    logic       standby_q;
    logic [7:0] app_code_q;
    logic       obj_en_q;
    logic       histo_en_q;
    wire        scl;
    wire        host_oe;
    wire        sda_out;
    wire        sda_oe;
    wire        sda_line;
    wire        cpu_rst;
    wire        osc_run;
    wire        pon_irq;
    wire        pdn_irq;
    wire  [7:0] req_code;
    wire        int_out;
    wire        int_oe;
    wire        int_line;
    int         bad_count = 0;
    int         checks    = 0;
    int         cycle_cnt = 0;
    int         rst_cnt   = 0;
    int         pon_cnt   = 0;
    int         pdn_cnt   = 0;
    logic [7:0] codes [2] = '{APP_CODE_BOOT, APP_CODE_MEAS};

    // Open-drain wires with pull-ups
    assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_oe;
    assign int_line = int_oe ? int_out : 1'b1;

    i2c_host_model host (
        .i_clk    (i_clk),
        .i_sda    (sda_line),
        .o_scl    (scl),
        .o_sda_oe (host_oe)
    );

    tof_host_control_registers dut (
        .i_clk                      (i_clk),
        .i_rst                      (i_rst),
        .i_scl                      (scl),
        .i_sda                      (sda_line),
        .o_sda_out                  (sda_out),
        .o_sda_oe                   (sda_oe),
        .i_fw_cpu_ready_set         (pulse_q[0]),
        .i_fw_app_valid             (pulse_q[1]),
        .i_fw_app_code              (app_code_q),
        .i_fw_standby               (standby_q),
        .i_object_result_evt        (pulse_q[2]),
        .i_histogram_ready_evt      (pulse_q[3]),
        .i_object_result_irq_enable (obj_en_q),
        .i_histogram_irq_enable     (histo_en_q),
        .o_cpu_global_rst           (cpu_rst),
        .o_osc_run                  (osc_run),
        .o_power_on_cpu_irq         (pon_irq),
        .o_power_down_cpu_irq       (pdn_irq),
        .o_requested_app_code       (req_code),
        .o_int_out                  (int_out),
        .o_int_oe                   (int_oe)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
        logic ok;
        host.write_reg(DEF_SLAVE_ADDR, ptr, dat, ok);
        chk("write ack", 8'h01, {7'h00, ok});
    endtask

    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] got;
        logic       ok;
        host.read_reg(ptr, got, ok);
        chk("read ack", 8'h01, {7'h00, ok});
        chk($sformatf("register %h", ptr), exp, got);
    endtask

    task automatic pulse(input int k);
        pulse_q[k] <= 1'b1;
        @(posedge i_clk);
        pulse_q <= 4'h0;
        @(posedge i_clk);
    endtask

    task automatic t_reset();
        chk("oscillator", 8'h01, {7'h00, osc_run});
        rd(ADDR_ENABLE, 8'h01);
        rd(ADDR_INT_FLAGS, 8'h00);
        chk("interrupt pin", 8'h01, {7'h00, int_line});
    endtask

    // Lower registers refused until firmware is up; foreign address ignored
    task automatic t_not_ready();
        logic ok;
        wr(ADDR_APP_REQ, APP_CODE_MEAS);
        rd(ADDR_APP_REQ, 8'h00);
        chk("requested code", 8'h00, req_code);
        host.write_reg(DEF_SLAVE_ADDR ^ 7'h01, ADDR_ENABLE, 8'h00, ok);
        chk("foreign address ack", 8'h00, {7'h00, ok});
        chk("power-down pulses", 8'h00, 8'(pdn_cnt));
    endtask

    task automatic t_ready_app();
        logic [7:0] got;
        logic       ok;
        pulse(0);
        rd(ADDR_ENABLE, 8'h41);
        wr(ADDR_ENABLE, 8'h01);
        rd(ADDR_ENABLE, 8'h41);
        chk("power-on pulses", 8'h00, 8'(pon_cnt));
        wr(ADDR_APP_REV, 8'h5A);
        rd(ADDR_APP_REV, 8'h5A);
        rd(8'hE5, 8'h00);
        foreach (codes[i]) begin
            wr(ADDR_APP_REQ, codes[i]);
            chk("requested code", codes[i], req_code);
            app_code_q <= codes[i];
            pulse(1);
            got = 8'h00;
            for (int n = 0; n < 3 && got !== codes[i]; n++) begin
                host.read_reg(ADDR_APP_RUNNING, got, ok);
            end
            chk("running code", codes[i], got);
        end
    endtask

    task automatic t_flags();
        pulse(2);
        rd(ADDR_INT_FLAGS, 8'h01);
        chk("masked pin", 8'h01, {7'h00, int_line});
        obj_en_q <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk("object pin", 8'h00, {7'h00, int_line});
        wr(ADDR_INT_FLAGS, 8'h02);
        rd(ADDR_INT_FLAGS, 8'h01);
        wr(ADDR_INT_FLAGS, 8'h01);
        rd(ADDR_INT_FLAGS, 8'h00);
        chk("released pin", 8'h01, {7'h00, int_line});
        pulse(2);
        rd(ADDR_INT_FLAGS, 8'h01);
        wr(ADDR_INT_FLAGS, 8'h01);
        pulse(3);
        repeat (3) @(posedge i_clk);
        chk("masked pin", 8'h01, {7'h00, int_line});
        histo_en_q <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk("histogram pin", 8'h00, {7'h00, int_line});
        rd(ADDR_INT_FLAGS, 8'h02);
        wr(ADDR_INT_FLAGS, 8'h02);
        rd(ADDR_INT_FLAGS, 8'h00);
        chk("released pin", 8'h01, {7'h00, int_line});
    endtask

    task automatic t_power();
        wr(ADDR_ENABLE, 8'h00);
        chk("power-down pulses", 8'h01, 8'(pdn_cnt));
        chk("oscillator", 8'h01, {7'h00, osc_run});
        standby_q <= 1'b1;
        @(posedge i_clk);
        standby_q <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk("oscillator", 8'h00, {7'h00, osc_run});
        rd(ADDR_ENABLE, 8'h40);
        wr(ADDR_ENABLE, 8'h01);
        chk("power-on pulses", 8'h01, 8'(pon_cnt));
        chk("oscillator", 8'h01, {7'h00, osc_run});
    endtask

    // Reset bit with oscillator bit kept high: no power-down side effect
    task automatic t_cpu_reset();
        wr(ADDR_ENABLE, 8'h81);
        repeat (8) @(posedge i_clk);
        chk("global reset cycles", 8'(CPU_RST_CYCLES), 8'(rst_cnt));
        rd(ADDR_ENABLE, 8'h01);
        chk("power-down pulses", 8'h01, 8'(pdn_cnt));
    endtask

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // Pulse counters and hang guard
    always @(posedge i_clk) begin
        cycle_cnt <= cycle_cnt + 1;
        rst_cnt   <= rst_cnt + int'(cpu_rst);
        pon_cnt   <= pon_cnt + int'(pon_irq);
        pdn_cnt   <= pdn_cnt + int'(pdn_irq);
        if (cycle_cnt == TIMEOUT) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        i_rst      = 1'b1;
        pulse_q    = 4'h0;
        standby_q  = 1'b0;
        app_code_q = 8'h00;
        obj_en_q   = 1'b0;
        histo_en_q = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        t_reset();
        t_not_ready();
        t_ready_app();
        t_flags();
        t_power();
        t_cpu_reset();
        end_of_test();
    end
endmodule // tof_host_control_registers_test
